// ==== hw/svb_front_end.sv ====
`timescale 1ns/1ns
module svb_front_end #(
  parameter int TEL_BIT_CYC = svb_pkg::TEL_BIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // pins from outside the clock domain
  input wire logic enable_i,
  input wire logic processor_power_ok_i,
  input wire logic vid_link_clock_line_i,
  input wire logic vid_link_data_line_i,
  // configuration from the nonvolatile store
  input wire logic [7:0] boot_voltage_source_select_i,
  input wire logic [1:0] fast_slew_sel_i,
  input wire logic soft_start_quarter_i,
  // measured rail currents for telemetry
  input wire logic [1:0][7:0] rail_current_i,
  // rail control
  output logic [1:0][7:0] voltage_code_o,
  output logic [1:0] rail_power_good_o,
  output logic [2:0] load_line_slope_o,
  output logic [1:0] vid_offset_o,
  output logic low_power_o,
  output logic telemetry_on_o,
  // link
  output logic vid_link_telemetry_alert_line_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // 0 enable, 1 power ok, 2 link clock, 3 link data
  wire [3:0] pin_raw = {vid_link_data_line_i, vid_link_clock_line_i,
                        processor_power_ok_i, enable_i};
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;

  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          meta_r[gs] <= 1'b0;
          sync_r[gs] <= 1'b0;
          prev_r[gs] <= 1'b0;
        end else begin
          meta_r[gs] <= pin_raw[gs];
          sync_r[gs] <= meta_r[gs];
          prev_r[gs] <= sync_r[gs];
        end
      end
    end
  endgenerate

  wire en_s = sync_r[0];
  wire en_rise = sync_r[0] & ~prev_r[0];
  wire pok_s = sync_r[1];
  wire pok_fall = ~sync_r[1] & prev_r[1];
  wire lclk_s = sync_r[2];
  wire ldat_s = sync_r[3];
  wire lclk_rise = sync_r[2] & ~prev_r[2];
  // start: data falls while the clock line is high
  wire frame_start = lclk_s & prev_r[2] & prev_r[3] & ~ldat_s;

  // ----------------------------------------------------------------
  // boot value resolution
  // ----------------------------------------------------------------
  logic [7:0] pin_code;
  always_comb begin
    unique case ({lclk_s, ldat_s})
      2'b00: pin_code = svb_pkg::CODE_1V10;
      2'b01: pin_code = svb_pkg::CODE_1V00;
      2'b10: pin_code = svb_pkg::CODE_0V90;
      2'b11: pin_code = svb_pkg::CODE_0V80;
    endcase
  end

  wire stored_sel = boot_voltage_source_select_i[svb_pkg::BOOT_SEL_BIT];
  wire [7:0] boot_nxt = stored_sel ?
    {1'b0, boot_voltage_source_select_i[6:0]} : pin_code;

  logic [7:0] boot_code_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) boot_code_r <= svb_pkg::CODE_1V10;
    else if (en_rise) boot_code_r <= boot_nxt;
  end

  // ----------------------------------------------------------------
  // link receiver
  // ----------------------------------------------------------------
  // only runs while power ok is high; a drop kills any partial frame
  logic rx_active_r;
  logic [4:0] rx_cnt_r;
  logic [23:0] rx_sh_r;
  logic pkt_vld_r;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !pok_s || !en_s) begin
      rx_active_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_sh_r <= '0;
      pkt_vld_r <= 1'b0;
    end else begin
      pkt_vld_r <= 1'b0;
      if (frame_start) begin
        rx_active_r <= 1'b1;
        rx_cnt_r <= '0;
      end else if (rx_active_r && lclk_rise) begin
        rx_sh_r <= {rx_sh_r[22:0], ldat_s};
        rx_cnt_r <= rx_cnt_r + 5'd1;
        if (rx_cnt_r == 5'(svb_pkg::PKT_BITS - 1)) begin
          rx_active_r <= 1'b0;
          pkt_vld_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  svb_pkg::svb_seq_e seq_r;
  wire cmd_ok = pkt_vld_r & (seq_r == svb_pkg::SEQ_ON);
  wire [1:0] cmd_sel = {rx_sh_r[svb_pkg::PKT_SEL_NB],
                        rx_sh_r[svb_pkg::PKT_SEL_CORE]};
  wire [7:0] cmd_vid = rx_sh_r[svb_pkg::PKT_VID_LSB +: 8];
  wire [2:0] cmd_ll = rx_sh_r[svb_pkg::PKT_LL_LSB +: 3];
  wire [1:0] cmd_ofs = rx_sh_r[svb_pkg::PKT_OFS_LSB +: 2];
  wire cmd_ll_upd = cmd_ok & rx_sh_r[svb_pkg::PKT_LL_UPD];
  wire cmd_ofs_upd = cmd_ok & rx_sh_r[svb_pkg::PKT_OFS_UPD];

  logic cfg_alert_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !en_s || pok_fall) begin
      load_line_slope_o <= svb_pkg::LL_INIT;
      vid_offset_o <= svb_pkg::OFS_INIT;
      low_power_o <= 1'b0;
      telemetry_on_o <= 1'b0;
      cfg_alert_r <= 1'b0;
    end else begin
      cfg_alert_r <= cmd_ll_upd | cmd_ofs_upd;
      if (cmd_ok) begin
        low_power_o <= rx_sh_r[svb_pkg::PKT_LOW_PWR];
        telemetry_on_o <= rx_sh_r[svb_pkg::PKT_TEL_EN];
      end
      if (cmd_ll_upd) load_line_slope_o <= cmd_ll;
      if (cmd_ofs_upd) vid_offset_o <= cmd_ofs;
    end
  end

  logic tel_vi_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !en_s || pok_fall) tel_vi_r <= 1'b0;
    else if (cmd_ok) tel_vi_r <= rx_sh_r[svb_pkg::PKT_TEL_VI];
  end

  // ----------------------------------------------------------------
  // ramp rate
  // ----------------------------------------------------------------
  // soft start only: the fraction applies while booting
  wire [9:0] fast_add = svb_pkg::SLEW_ADD[fast_slew_sel_i];
  wire [9:0] ss_add = soft_start_quarter_i ? (fast_add >> 2) :
                      (fast_add >> 1);
  wire [9:0] ramp_add = (seq_r == svb_pkg::SEQ_RAMP) ? ss_add :
                        fast_add;

  // ----------------------------------------------------------------
  // per-rail ramp engines
  // ----------------------------------------------------------------
  logic [1:0][7:0] tgt_r;
  logic [1:0][11:0] acc_r;
  logic [1:0] up_r;
  logic [1:0] up_done;

  genvar gr;
  generate
    for (gr = 0; gr < 2; gr++) begin : g_rail
      wire [7:0] code = voltage_code_o[gr];
      wire moving = (code != tgt_r[gr]);
      wire [11:0] acc_sum = acc_r[gr] + {2'b00, ramp_add};
      wire step = moving & (acc_sum >= svb_pkg::VID_STEP_UNITS);
      // lower code means higher voltage
      wire [7:0] code_step = (tgt_r[gr] < code) ? code - 8'h0001 :
                             code + 8'h0001;
      wire [7:0] code_nxt = step ? code_step : code;
      wire [11:0] acc_nxt = !moving ? 12'h0000 :
        step ? acc_sum - svb_pkg::VID_STEP_UNITS : acc_sum;
      wire vid_hit = cmd_ok & cmd_sel[gr];
      assign up_done[gr] = up_r[gr] & step & (code_step == tgt_r[gr]);

      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !en_s) begin
          // disable drops the rail at once; no soft stop
          voltage_code_o[gr] <= svb_pkg::CODE_ZERO;
          tgt_r[gr] <= svb_pkg::CODE_ZERO;
          acc_r[gr] <= '0;
          up_r[gr] <= 1'b0;
        end else begin
          voltage_code_o[gr] <= code_nxt;
          acc_r[gr] <= acc_nxt;
          if (up_done[gr]) up_r[gr] <= 1'b0;
          if (en_rise) begin
            tgt_r[gr] <= boot_nxt;
            up_r[gr] <= 1'b0;
          end else if (pok_fall) begin
            tgt_r[gr] <= boot_code_r;
            up_r[gr] <= 1'b0;
          end else if (vid_hit) begin
            tgt_r[gr] <= cmd_vid;
            up_r[gr] <= (cmd_vid < code);
          end
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !en_s) rail_power_good_o[gr] <= 1'b0;
        else if (seq_r == svb_pkg::SEQ_RAMP && !moving)
          rail_power_good_o[gr] <= 1'b1;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // power-on sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !en_s) begin
      seq_r <= svb_pkg::SEQ_OFF;
    end else begin
      unique case (seq_r)
        svb_pkg::SEQ_OFF:
          if (en_rise) seq_r <= svb_pkg::SEQ_RAMP;
        svb_pkg::SEQ_RAMP:
          if (&rail_power_good_o) seq_r <= svb_pkg::SEQ_ON;
        svb_pkg::SEQ_ON:
          seq_r <= svb_pkg::SEQ_ON;
        default:
          seq_r <= svb_pkg::SEQ_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // telemetry and alert line
  // ----------------------------------------------------------------
  // the device only ever drives this line; clock and data are inputs
  wire tel_alert = |up_done | cfg_alert_r;
  wire tel_hold = ~pok_s | ~en_s;

  svb_telem_tx #(
    .BIT_CYC(TEL_BIT_CYC),
    .ALERT_LEN(svb_pkg::ALERT_BITS)
  ) u_telem (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .hold_high_i(tel_hold),
    .tel_en_i(telemetry_on_o),
    .tel_vi_i(tel_vi_r),
    .alert_i(tel_alert),
    .code_i(voltage_code_o),
    .cur_i(rail_current_i),
    .line_o(vid_link_telemetry_alert_line_o)
  );

endmodule

// ==== shared/svb_pkg.sv ====
//
// Overview of operation
// - ramp both rails to boot, per-rail power good
// - soft start at half or quarter fast slew
// - decode boot level from link pins at enable
// - pin pairs give 1.1, 1.0, 0.9, 0.8 volt
// - boot value latched, reused across power-ok toggles
// - boot register bit 7 selects stored code
// - link commands honoured only while power-ok high
// - power-ok loss resets link, telemetry high, boot
// - three wires, each party drives its own
// - decode voltage, low-power, telemetry, slope, offset commands
// - telemetry sends voltage or voltage plus current
// - alert on upward change, offset or slope change
// - 8-bit voltage code moves rails at fast slew
// - code 0 is 1.55 V, 6.25 mV steps
//
package svb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // ramp accumulator unit is 2.5 uV, one code step is 6.25 mV
  localparam int RAMP_UNIT_NV = 2500;
  localparam int VID_STEP_UV = 6250;
  localparam logic [11:0] VID_STEP_UNITS =
    12'(VID_STEP_UV * 1000 / RAMP_UNIT_NV);
  localparam int FAST_MV_US_0 = 10;
  localparam int FAST_MV_US_1 = 15;
  localparam int FAST_MV_US_2 = 20;
  localparam int FAST_MV_US_3 = 25;
  localparam logic [9:0] SLEW_ADD [4] = '{
    10'(FAST_MV_US_0 * CLK_PERIOD_NS * 1000 / RAMP_UNIT_NV),
    10'(FAST_MV_US_1 * CLK_PERIOD_NS * 1000 / RAMP_UNIT_NV),
    10'(FAST_MV_US_2 * CLK_PERIOD_NS * 1000 / RAMP_UNIT_NV),
    10'(FAST_MV_US_3 * CLK_PERIOD_NS * 1000 / RAMP_UNIT_NV)};
  localparam int TEL_BIT_NS = 1000;
  localparam int TEL_BIT_CYCLES = TEL_BIT_NS / CLK_PERIOD_NS;
  localparam int ALERT_BITS = 4;

  // ----------------------------------------------------------------
  // voltage codes: volts = 1.55 - 0.00625 * code
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_1V10 = 8'h0048;
  localparam logic [7:0] CODE_1V00 = 8'h0058;
  localparam logic [7:0] CODE_0V90 = 8'h0068;
  localparam logic [7:0] CODE_0V80 = 8'h0078;
  localparam logic [7:0] CODE_ZERO = 8'h00F8;
  localparam int BOOT_SEL_BIT = 7;

  // ----------------------------------------------------------------
  // packet layout, 24 bits, msb first
  // ----------------------------------------------------------------
  localparam int PKT_BITS = 24;
  localparam int PKT_SEL_CORE = 23;
  localparam int PKT_SEL_NB = 22;
  localparam int PKT_LOW_PWR = 21;
  localparam int PKT_TEL_EN = 20;
  localparam int PKT_TEL_VI = 19;
  localparam int PKT_LL_UPD = 18;
  localparam int PKT_OFS_UPD = 17;
  localparam int PKT_VID_LSB = 8;
  localparam int PKT_LL_LSB = 5;
  localparam int PKT_OFS_LSB = 3;
  localparam logic [2:0] LL_INIT = 3'h0;
  localparam logic [1:0] OFS_INIT = 2'h0;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_RAMP = 2'b01,
    SEQ_ON = 2'b11
  } svb_seq_e;

  typedef enum logic [1:0] {
    TEL_IDLE = 2'b00,
    TEL_SEND = 2'b01,
    TEL_ALERT = 2'b11
  } svb_tel_e;

endpackage

// ==== hw/svb_telem_tx.sv ====
`timescale 1ns/1ns
module svb_telem_tx #(
  parameter int BIT_CYC = svb_pkg::TEL_BIT_CYCLES,
  parameter int ALERT_LEN = svb_pkg::ALERT_BITS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic hold_high_i,
  input wire logic tel_en_i,
  input wire logic tel_vi_i,
  input wire logic alert_i,
  // telemetry data
  input wire logic [1:0][7:0] code_i,
  input wire logic [1:0][7:0] cur_i,
  // line
  output logic line_o
);

  // ----------------------------------------------------------------
  // bit rate divider
  // ----------------------------------------------------------------
  logic [15:0] div_r;
  wire bit_en = (div_r == 16'(BIT_CYC - 1));
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || hold_high_i || bit_en) div_r <= '0;
    else div_r <= div_r + 16'h0001;
  end

  // ----------------------------------------------------------------
  // frame: start bit low, then codes, then currents in vi mode
  // ----------------------------------------------------------------
  svb_pkg::svb_tel_e st_r;
  logic [32:0] sh_r;
  logic [5:0] left_r;
  logic pend_r;
  wire [32:0] frame = {1'b0, code_i[0], code_i[1], cur_i[0], cur_i[1]};
  wire [5:0] frame_len = tel_vi_i ? 6'd33 : 6'd17;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || hold_high_i) begin
      st_r <= svb_pkg::TEL_IDLE;
      sh_r <= '0;
      left_r <= '0;
      pend_r <= 1'b0;
      line_o <= 1'b1;
    end else begin
      // a new alert wins over the clear of the pending one
      if (alert_i) pend_r <= 1'b1;
      else if (bit_en && st_r == svb_pkg::TEL_IDLE) pend_r <= 1'b0;
      if (bit_en) begin
        unique case (st_r)
          svb_pkg::TEL_IDLE: begin
            if (pend_r) begin
              st_r <= svb_pkg::TEL_ALERT;
              left_r <= 6'(ALERT_LEN - 1);
              line_o <= 1'b0;
            end else if (tel_en_i) begin
              st_r <= svb_pkg::TEL_SEND;
              sh_r <= {frame[31:0], 1'b0};
              left_r <= frame_len - 6'd1;
              line_o <= frame[32];
            end else begin
              line_o <= 1'b1;
            end
          end
          svb_pkg::TEL_SEND: begin
            if (left_r == 6'd0) begin
              st_r <= svb_pkg::TEL_IDLE;
              line_o <= 1'b1;
            end else begin
              left_r <= left_r - 6'd1;
              line_o <= sh_r[32];
              sh_r <= {sh_r[31:0], 1'b0};
            end
          end
          svb_pkg::TEL_ALERT: begin
            if (left_r == 6'd0) begin
              st_r <= svb_pkg::TEL_IDLE;
              line_o <= 1'b1;
            end else begin
              left_r <= left_r - 6'd1;
            end
          end
          default: st_r <= svb_pkg::TEL_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== verif/svb_front_end_checker.sv ====
`timescale 1ns/1ns
module svb_front_end_checker #(
  parameter int TEL_BIT_CYC = svb_pkg::TEL_BIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic enable_i,
  input wire logic processor_power_ok_i,
  input wire logic [1:0][7:0] voltage_code_o,
  input wire logic [1:0] rail_power_good_o,
  input wire logic [2:0] load_line_slope_o,
  input wire logic [1:0] vid_offset_o,
  input wire logic low_power_o,
  input wire logic telemetry_on_o,
  input wire logic vid_link_telemetry_alert_line_o
);
  localparam logic [15:0] ALERT_CYC = 16'(svb_pkg::ALERT_BITS * TEL_BIT_CYC);
  // ----------------
  // low run length
  // ----------------
  // frames pull the line low too, so only count with telemetry off
  logic [15:0] low_run_r;
  logic [15:0] low_run_nxt;
  assign low_run_nxt = (vid_link_telemetry_alert_line_o || telemetry_on_o)
    ? 16'h0000 : low_run_r + 16'h0001;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      low_run_r <= 16'h0000;
    end else begin
      low_run_r <= low_run_nxt;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_en_held;
    enable_i [*6];
  endsequence
  sequence s_processor_power_ok_low;
    !processor_power_ok_i [*6];
  endsequence
  property p_step(r);
    s_en_held |-> (voltage_code_o[r] - $past(voltage_code_o[r]))
      inside {8'h00, 8'h01, 8'hFF};
  endproperty
  a_rails_off:
    assert property (!enable_i [*6] |-> rail_power_good_o == 2'h0 &&
      voltage_code_o == {2{svb_pkg::CODE_ZERO}})
    else $error("rails not off");
  a_core_step:
    assert property (p_step(0)) else $error("core code jumped");
  a_nb_step:
    assert property (p_step(1)) else $error("nb code jumped");
  a_pg_rise:
    assert property ($rose(rail_power_good_o[0]) |->
      $stable(voltage_code_o[0]) && voltage_code_o[0] != 8'hF8)
    else $error("good before target");
  a_pg_hold:
    assert property (enable_i [*8] |-> !$fell(rail_power_good_o[0]) &&
      !$fell(rail_power_good_o[1]))
    else $error("good dropped");
  a_line_processor_power_ok:
    assert property (s_processor_power_ok_low |-> vid_link_telemetry_alert_line_o)
    else $error("line low without power ok");
  a_init_processor_power_ok:
    assert property (s_processor_power_ok_low |-> load_line_slope_o == 3'h0 &&
      vid_offset_o == 2'h0 && !low_power_o && !telemetry_on_o)
    else $error("settings kept without power ok");
  a_slope_gate:
    assert property ($changed(load_line_slope_o) && load_line_slope_o != 3'h0
      |-> $past(rail_power_good_o) == 2'h3)
    else $error("slope changed before good");
  a_alert_len:
    assert property ($rose(vid_link_telemetry_alert_line_o) &&
      !telemetry_on_o && processor_power_ok_i |-> low_run_r == ALERT_CYC)
    else $error("alert length wrong");
endmodule
bind svb_front_end svb_front_end_checker #(.TEL_BIT_CYC(TEL_BIT_CYC)) u_chk (
  .ref_clk_i, .sys_rst_i, .enable_i, .processor_power_ok_i,
  .voltage_code_o, .rail_power_good_o, .load_line_slope_o, .vid_offset_o,
  .low_power_o, .telemetry_on_o, .vid_link_telemetry_alert_line_o);

// ==== verif/svb_cpu_model.sv ====
`timescale 1ns/1ns
module svb_cpu_model (
  // link lines owned by the processor side
  output logic clk_o,
  output logic dat_o
);
  localparam int HALF_NS = 400;
  // ----------------
  // link clock idles high and toggles inside a packet; pins() can also hold it low between packets for boot decode
  // ----------------
  initial begin
    clk_o = 1'h1;
    dat_o = 1'h1;
  end
  task automatic pins(input logic c, d);
    clk_o = c;
    dat_o = d;
  endtask
  task automatic send(input logic [23:0] p);
    clk_o = 1'h1;
    // odd lead-in keeps link edges off the reference clock grid
    #(HALF_NS + 37);
    dat_o = 1'h0;
    #HALF_NS;
    for (int i = 23; i >= 0; i--) begin
      clk_o = 1'h0;
      dat_o = p[i];
      #HALF_NS;
      clk_o = 1'h1;
      #(i == 0 ? HALF_NS / 2 : HALF_NS);
    end
    dat_o = 1'h1;
  endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  // ----------------
  // stimulus and counters
  // ----------------
  localparam int TBC = 4;
  logic clk = 1'h0, rst = 1'h1, en = 1'h0, processor_power_ok = 1'h0, qtr = 1'h0;
  logic lclk, ldat, lowp, telon, line;
  logic [7:0] bsel = 8'h00;
  logic [1:0] rate = 2'h0;
  logic [1:0] pg, ofs;
  logic [2:0] slope;
  logic [1:0][7:0] code;
  logic [1:0][7:0] cur = {8'h3C, 8'hA5};
  int err_count = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  svb_cpu_model u_cpu (.clk_o(lclk), .dat_o(ldat));
  svb_front_end #(.TEL_BIT_CYC(TBC)) DUT (
    .ref_clk_i(clk), .sys_rst_i(rst), .enable_i(en),
    .processor_power_ok_i(processor_power_ok), .vid_link_clock_line_i(lclk),
    .vid_link_data_line_i(ldat), .boot_voltage_source_select_i(bsel),
    .fast_slew_sel_i(rate), .soft_start_quarter_i(qtr),
    .rail_current_i(cur), .voltage_code_o(code), .rail_power_good_o(pg),
    .load_line_slope_o(slope), .vid_offset_o(ofs), .low_power_o(lowp),
    .telemetry_on_o(telon), .vid_link_telemetry_alert_line_o(line));
  // ----------------
  // helpers
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic step(inout int n);
    tick(1);
    n++;
    if (n > 9000) begin
      err_count++;
      $display("[FAIL] %0t wait timed out", $time);
      give_verdict();
    end
  endtask
  function automatic logic [7:0] code_of(input int mv);
    return 8'((1550000 - mv * 1000) / 6250);
  endfunction
  function automatic logic [23:0] pkt(input logic [1:0] sel,
      input logic [2:0] flg, input logic [1:0] upd, input logic [7:0] c,
      input logic [2:0] ll, input logic [1:0] of);
    return {sel, flg, upd, 1'h0, c, ll, of, 3'h0};
  endfunction
  // ----------------
  // scenarios
  // ----------------
  // ramp time is only known to within one code step
  task automatic t_boot_pins();
    int n, r, dv, st;
    for (int i = 0; i < 4; i++) begin
      en = 1'h0;
      tick(8);
      chk({pg, code}, {2'h0, {2{code_of(0)}}}, "rails off");
      u_cpu.pins(i[1], i[0]);
      rate = 2'(i);
      qtr = i[0];
      tick(2);
      en = 1'h1;
      n = 0;
      while (pg !== 2'h3) step(n);
      r = 10 + 5 * i;
      dv = qtr ? 4 : 2;
      st = code_of(0) - code_of(1100 - 100 * i);
      chk(n >= st * 625 * dv / (10 * r) - 2 &&
        n <= (st + 1) * 625 * dv / (10 * r) + 10, 1'h1, "ramp");
      chk(code, {2{code_of(1100 - 100 * i)}}, "pin boot");
    end
  endtask
  task automatic t_boot_reg();
    int n = 0;
    en = 1'h0;
    bsel = 8'hB0;
    u_cpu.pins(1'h0, 1'h0);
    rate = 2'h3;
    qtr = 1'h0;
    tick(8);
    en = 1'h1;
    while (pg !== 2'h3) step(n);
    chk(code, 16'h3030, "stored boot");
    u_cpu.pins(1'h1, 1'h1);
  endtask
  task automatic t_link();
    int n = 0;
    logic [31:0] f;
    tick(4);
    u_cpu.send(pkt(2'h2, 3'h0, 2'h3, 8'h38, 3'h5, 2'h2));
    while (line !== 1'h0) step(n);
    n = 0;
    while (line === 1'h0) step(n);
    chk(n, svb_pkg::ALERT_BITS * TBC, "alert length");
    chk({slope, ofs, lowp, telon}, {3'h5, 2'h2, 2'h0}, "regs");
    while (code[0] !== 8'h38) step(n);
    chk(code[1], 8'h30, "other rail");
    u_cpu.send(pkt(2'h0, 3'h7, 2'h0, 8'h00, 3'h0, 2'h0));
    n = 0;
    while (line !== 1'h0) step(n);
    tick(TBC + TBC / 2);
    for (int k = 31; k >= 0; k--) begin
      f[k] = line;
      tick(TBC);
    end
    chk(f, {8'h38, 8'h30, cur[0], cur[1]}, "frame");
    chk({lowp, telon}, 2'h3, "flags");
  endtask
  task automatic t_processor_power_ok();
    int n = 0;
    logic [31:0] f;
    bsel = 8'h00;
    processor_power_ok = 1'h0;
    tick(10);
    chk({line, slope, ofs, lowp, telon}, 8'h80, "power ok low");
    u_cpu.send(pkt(2'h3, 3'h0, 2'h2, 8'h10, 3'h3, 2'h0));
    tick(10);
    chk({slope, code}, {3'h0, 16'h3030}, "ignored");
    processor_power_ok = 1'h1;
    tick(20);
    chk(code, 16'h3030, "boot kept");
    u_cpu.send(pkt(2'h1, 3'h0, 2'h0, 8'h20, 3'h0, 2'h0));
    while (code[1] !== 8'h20) step(n);
    n = 0;
    while (line !== 1'h0) step(n);
    chk(n < 8, 1'h1, "rise alert");
    // voltage-only frame: 16 code bits, then the line idles high
    u_cpu.send(pkt(2'h0, 3'h2, 2'h0, 8'h00, 3'h0, 2'h0));
    n = 0;
    while (line !== 1'h0) step(n);
    tick(TBC + TBC / 2);
    for (int k = 15; k >= 0; k--) begin
      f[k] = line;
      tick(TBC);
    end
    chk({f[15:0], line}, {16'h3020, 1'h1}, "voltage only");
  endtask
  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tick(20);
    rst = 1'h0;
    processor_power_ok = 1'h1;
    tick(2);
    t_boot_pins();
    t_boot_reg();
    t_link();
    t_processor_power_ok();
    give_verdict();
  end
endmodule
